//--- common/lsr_pkg.sv
// Shared constants for the serial command receiver link.
package lsr_pkg;
   localparam logic [5:0] ADDR_BASE = 6'h1C;
   localparam int BYTE_BITS = 8;
   localparam int SYNC_STAGES = 3;
   localparam logic [5:0] RAM_LAST = 6'h27;
   localparam logic [5:0] PTR_STEP_STATIC = 6'h08;
   localparam logic [5:0] PTR_STEP_MUX2 = 6'h04;
   localparam logic [5:0] PTR_STEP_MUX3 = 6'h03;
   localparam logic [5:0] PTR_STEP_MUX4 = 6'h02;
   localparam logic [1:0] MODE_STATIC = 2'h1;
   localparam logic [1:0] MODE_MUX2 = 2'h2;
   localparam logic [1:0] MODE_MUX3 = 2'h3;
   localparam logic [1:0] MODE_MUX4 = 2'h0;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [5:0] PTR_RESET = 6'h00;
   localparam logic [2:0] SUB_RESET = 3'h0;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam int SAVE_BUSY_CYCLES = 6;
   localparam int MASTER_HALF_CYCLES = 50;
   localparam logic [7:0] CMD_LOAD_PTR_MASK = 8'h40;
   localparam logic [7:0] CMD_MODE_SET = 8'h40;
   localparam logic [7:0] CMD_DEV_SEL = 8'h60;
   localparam logic [7:0] CMD_DEV_SEL_MASK = 8'h78;
   localparam logic [7:0] CMD_MODE_MASK = 8'h60;
endpackage

//--- common/lsr_if.sv
// Two-wire bus joining the master end and the receiver end.
`timescale 1ns/1ps
interface lsr_if;
   logic sda_o_m;
   logic sda_oe_m;
   logic scl_o_m;
   logic scl_oe_m;
   logic sda_o_s;
   logic sda_oe_s;
   logic scl_o_s;
   logic scl_oe_s;
   logic sda_i;
   logic scl_i;
   // Open drain wired-and with pull-up
   assign sda_i = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
   assign scl_i = !((scl_oe_m && !scl_o_m) || (scl_oe_s && !scl_o_s));
   modport master (output sda_o_m, output sda_oe_m, output scl_o_m, output scl_oe_m,
      input sda_i, input scl_i);
   modport device (output sda_o_s, output sda_oe_s, output scl_o_s, output scl_oe_s,
      input sda_i, input scl_i);
endinterface

//--- verilog/lsr_device.sv
// Receive-only two-wire slave front end of a segment display driver.
`timescale 1ns/1ps
module lsr_device (
   input wire logic mclk,
   input wire logic rstn,
   lsr_if.device bus,
   input wire logic address_select_pin,
   input wire logic subaddress_in_bit0,
   input wire logic subaddress_in_bit1,
   input wire logic subaddress_in_bit2,
   input wire logic power_saving,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic ram_we,
   output logic [5:0] ram_addr,
   output logic [7:0] ram_data,
   output logic [1:0] drive_mode
);
   typedef enum logic [4:0] {
      LSR_IDLE = 5'b00001,
      LSR_ADDR = 5'b00010,
      LSR_CMD = 5'b00100,
      LSR_DATA = 5'b01000,
      LSR_IGNORE = 5'b10000
   } lsr_state_e;

   logic [2:0] sda_sync, scl_sync;
   logic sda_f, scl_f;
   lsr_state_e state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic ack_drive, next_ack_drive;
   logic in_ack, next_in_ack;
   logic [5:0] ptr, next_ptr;
   logic [2:0] sub_cnt, next_sub_cnt;
   logic [1:0] mode, next_mode;
   logic [3:0] busy, next_busy;
   logic stretch, next_stretch;
   logic next_cmd_valid, next_ram_we;
   logic [7:0] next_cmd_byte, next_ram_data;
   logic [5:0] next_ram_addr;
   logic [2:0] hw_sub;

   function automatic logic [5:0] ptr_step(input logic [1:0] m);
      unique case (m)
         lsr_pkg::MODE_STATIC: ptr_step = lsr_pkg::PTR_STEP_STATIC;
         lsr_pkg::MODE_MUX2: ptr_step = lsr_pkg::PTR_STEP_MUX2;
         lsr_pkg::MODE_MUX3: ptr_step = lsr_pkg::PTR_STEP_MUX3;
         default: ptr_step = lsr_pkg::PTR_STEP_MUX4;
      endcase
   endfunction

   assign hw_sub = {subaddress_in_bit2, subaddress_in_bit1, subaddress_in_bit0};

   // Filtered levels move only when the last two stages agree
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sda_sync <= 3'h7;
         scl_sync <= 3'h7;
         sda_f <= 1'b1;
         scl_f <= 1'b1;
      end else begin
         sda_sync <= {sda_sync[1:0], bus.sda_i};
         scl_sync <= {scl_sync[1:0], bus.scl_i};
         if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
         end
         if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
         end
      end
   end

   logic sda_d, scl_d;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sda_d <= 1'b1;
         scl_d <= 1'b1;
      end else begin
         sda_d <= sda_f;
         scl_d <= scl_f;
      end
   end

   logic start_det, stop_det, scl_rise, scl_fall;
   assign start_det = scl_f && scl_d && sda_d && !sda_f;
   assign stop_det = scl_f && scl_d && !sda_d && sda_f;
   assign scl_rise = scl_f && !scl_d;
   assign scl_fall = !scl_f && scl_d;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_ack_drive = ack_drive;
      next_in_ack = in_ack;
      next_ptr = ptr;
      next_sub_cnt = sub_cnt;
      next_mode = mode;
      next_busy = (busy != 4'h0) ? busy - 4'h1 : 4'h0;
      next_stretch = stretch;
      next_cmd_valid = 1'b0;
      next_cmd_byte = cmd_byte;
      next_ram_we = 1'b0;
      next_ram_addr = ram_addr;
      next_ram_data = ram_data;
      if (stretch && busy == 4'h0) begin
         next_stretch = 1'b0;
      end
      if (start_det) begin
         next_state = LSR_ADDR;
         next_bit_cnt = lsr_pkg::BIT_CNT_RESET;
         next_ack_drive = 1'b0;
         next_in_ack = 1'b0;
      end else if (stop_det) begin
         next_state = LSR_IDLE;
         next_ack_drive = 1'b0;
         next_in_ack = 1'b0;
      end else if (state != LSR_IDLE && state != LSR_IGNORE) begin
         if (scl_rise && !in_ack) begin
            // Count has no ceiling beyond the byte itself
            next_shreg = {shreg[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
         end
         if (scl_fall && in_ack) begin
            next_in_ack = 1'b0;
            next_ack_drive = 1'b0;
            // Data byte is digested after its ack; with power_saving SCL is held low until the SAVE_BUSY_CYCLES count runs out
            if (power_saving && state == LSR_DATA) begin
               next_busy = 4'(lsr_pkg::SAVE_BUSY_CYCLES);
               next_stretch = 1'b1;
            end
         end else if (scl_fall && bit_cnt == 4'(lsr_pkg::BYTE_BITS)) begin
            next_bit_cnt = lsr_pkg::BIT_CNT_RESET;
            next_in_ack = 1'b1;
            unique case (state)
               LSR_ADDR: begin
                  if (shreg[7:1] == {lsr_pkg::ADDR_BASE, address_select_pin} && !shreg[0]) begin
                     next_ack_drive = 1'b1;
                     next_state = LSR_CMD;
                  end else begin
                     next_state = LSR_IGNORE;
                     next_in_ack = 1'b0;
                  end
               end
               LSR_CMD: begin
                  next_ack_drive = 1'b1;
                  next_cmd_valid = 1'b1;
                  next_cmd_byte = shreg;
                  if (!shreg[7]) begin
                     next_state = LSR_DATA;
                  end
                  if (!shreg[6]) begin
                     next_ptr = shreg[5:0];
                  end else if ((shreg & lsr_pkg::CMD_DEV_SEL_MASK) == lsr_pkg::CMD_DEV_SEL) begin
                     next_sub_cnt = shreg[2:0];
                  end else if ((shreg & lsr_pkg::CMD_MODE_MASK) == lsr_pkg::CMD_MODE_SET) begin
                     next_mode = shreg[1:0];
                  end
               end
               LSR_DATA: begin
                  next_ack_drive = (sub_cnt == hw_sub);
                  next_ram_we = (sub_cnt == hw_sub);
                  next_ram_addr = ptr;
                  next_ram_data = shreg;
                  if (ptr + ptr_step(mode) > lsr_pkg::RAM_LAST) begin
                     next_ptr = lsr_pkg::PTR_RESET;
                     next_sub_cnt = sub_cnt + 3'h1;
                  end else begin
                     next_ptr = ptr + ptr_step(mode);
                  end
               end
               default: begin
                  next_in_ack = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= LSR_IDLE;
         bit_cnt <= lsr_pkg::BIT_CNT_RESET;
         shreg <= 8'h00;
         ack_drive <= 1'b0;
         in_ack <= 1'b0;
         ptr <= lsr_pkg::PTR_RESET;
         sub_cnt <= lsr_pkg::SUB_RESET;
         mode <= lsr_pkg::MODE_RESET;
         busy <= 4'h0;
         stretch <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_byte <= 8'h00;
         ram_we <= 1'b0;
         ram_addr <= lsr_pkg::PTR_RESET;
         ram_data <= 8'h00;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         ack_drive <= next_ack_drive;
         in_ack <= next_in_ack;
         ptr <= next_ptr;
         sub_cnt <= next_sub_cnt;
         mode <= next_mode;
         busy <= next_busy;
         stretch <= next_stretch;
         cmd_valid <= next_cmd_valid;
         cmd_byte <= next_cmd_byte;
         ram_we <= next_ram_we;
         ram_addr <= next_ram_addr;
         ram_data <= next_ram_data;
      end
   end

   assign drive_mode = mode;
   // Acknowledge is the only thing ever put on SDA
   assign bus.sda_o_s = 1'b0;
   assign bus.sda_oe_s = ack_drive;
   assign bus.scl_o_s = 1'b0;
   assign bus.scl_oe_s = stretch;
endmodule

//--- verilog/lsr_master.sv
// Bus master end: writes one address, a command list and display bytes.
`timescale 1ns/1ps
module lsr_master (
   input wire logic mclk,
   input wire logic rstn,
   lsr_if.master bus,
   input wire logic go,
   input wire logic addr_lsb,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_take,
   output logic busy,
   output logic nack_seen
);
   typedef enum logic [3:0] {
      LSM_IDLE = 4'b0001,
      LSM_START = 4'b0010,
      LSM_BITS = 4'b0100,
      LSM_STOP = 4'b1000
   } lsm_state_e;
   lsm_state_e state, next_state;
   logic [6:0] tick, next_tick;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [8:0] sh, next_sh;
   logic phase, next_phase;
   logic last, next_last;
   logic sda_lo, next_sda_lo, scl_lo, next_scl_lo;
   logic next_tx_take, next_busy, next_nack;
   logic [2:0] scl_sync;
   logic scl_hi;

   // Reads back SCL so a held-low clock from the receiver stalls us
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scl_sync <= 3'h7;
         scl_hi <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], bus.scl_i};
         if (scl_sync[1] == scl_sync[2]) begin
            scl_hi <= scl_sync[2];
         end
      end
   end

   always_comb begin
      next_state = state;
      next_tick = (tick != 7'h00) ? tick - 7'h01 : 7'h00;
      next_bit_cnt = bit_cnt;
      next_sh = sh;
      next_phase = phase;
      next_last = last;
      next_sda_lo = sda_lo;
      next_scl_lo = scl_lo;
      next_tx_take = 1'b0;
      next_busy = busy;
      next_nack = nack_seen;
      unique case (state)
         LSM_IDLE: begin
            // Idle bus only, both lines high
            if (go && scl_hi && bus.sda_i) begin
               next_state = LSM_START;
               next_busy = 1'b1;
               next_nack = 1'b0;
               next_sda_lo = 1'b1;
               next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
               next_sh = {lsr_pkg::ADDR_BASE, addr_lsb, 1'b0, 1'b1};
               next_bit_cnt = 4'h0;
               next_last = 1'b0;
            end
         end
         LSM_START: begin
            if (tick == 7'h00) begin
               next_scl_lo = 1'b1;
               next_phase = 1'b0;
               next_state = LSM_BITS;
               next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
            end
         end
         LSM_BITS: begin
            if (tick == 7'h00) begin
               if (scl_lo) begin
                  if (!phase) begin
                     next_sda_lo = !sh[8];
                     next_phase = 1'b1;
                     next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
                  end else begin
                     next_scl_lo = 1'b0;
                     next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
                  end
               end else if (scl_hi) begin
                  // Ninth pulse samples acknowledge
                  if (bit_cnt == 4'h8 && bus.sda_i) begin
                     next_nack = 1'b1;
                  end
                  next_scl_lo = 1'b1;
                  next_phase = 1'b0;
                  next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
                  next_sh = {sh[7:0], 1'b1};
                  if (bit_cnt == 4'h8) begin
                     next_bit_cnt = 4'h0;
                     if (last) begin
                        next_state = LSM_STOP;
                        next_sda_lo = 1'b1;
                     end else begin
                        next_sh = {tx_byte, 1'b1};
                        next_last = tx_last;
                        next_tx_take = 1'b1;
                     end
                  end else begin
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
         end
         LSM_STOP: begin
            if (tick == 7'h00) begin
               if (scl_lo) begin
                  next_scl_lo = 1'b0;
                  next_tick = 7'(lsr_pkg::MASTER_HALF_CYCLES);
               end else if (scl_hi) begin
                  next_sda_lo = 1'b0;
                  next_state = LSM_IDLE;
                  next_busy = 1'b0;
               end
            end
         end
         default: next_state = LSM_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= LSM_IDLE;
         tick <= 7'h00;
         bit_cnt <= 4'h0;
         sh <= 9'h1FF;
         phase <= 1'b0;
         last <= 1'b0;
         sda_lo <= 1'b0;
         scl_lo <= 1'b0;
         tx_take <= 1'b0;
         busy <= 1'b0;
         nack_seen <= 1'b0;
      end else begin
         state <= next_state;
         tick <= next_tick;
         bit_cnt <= next_bit_cnt;
         sh <= next_sh;
         phase <= next_phase;
         last <= next_last;
         sda_lo <= next_sda_lo;
         scl_lo <= next_scl_lo;
         tx_take <= next_tx_take;
         busy <= next_busy;
         nack_seen <= next_nack;
      end
   end

   assign bus.sda_o_m = 1'b0;
   assign bus.sda_oe_m = sda_lo;
   assign bus.scl_o_m = 1'b0;
   assign bus.scl_oe_m = scl_lo;
endmodule

//--- dv/lsr_monitor.sv
// Protocol checks on the two-wire link between master and receiver ends.
`timescale 1ns/1ps
module lsr_monitor (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sda_o_s,
   input wire logic sda_oe_s,
   input wire logic scl_o_s,
   input wire logic scl_oe_s,
   input wire logic sda_i,
   input wire logic scl_i
);
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic sda_q;
   logic scl_q;
   // Clock rises since START; 8 means the ack slot comes next
   always_comb begin
      next_bit_cnt = bit_cnt;
      if (scl_i && scl_q && sda_q && !sda_i) begin
         next_bit_cnt = 4'h0;
      end else if (scl_i && !scl_q) begin
         next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      end
   end
   // Idle bus levels at reset, so no false START is seen on release
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt <= 4'h0;
         sda_q <= 1'b1;
         scl_q <= 1'b1;
      end else begin
         bit_cnt <= next_bit_cnt;
         sda_q <= sda_i;
         scl_q <= scl_i;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_low_only;
      !sda_o_s && !scl_o_s && (!sda_oe_s || bit_cnt == 4'h8 || bit_cnt == 4'h0);
   endproperty
   a_low_only: assert property (p_low_only)
      else $error("receiver drives a line high");
   property p_ack_slot;
      $rose(sda_oe_s) |-> bit_cnt == 4'h8;
   endproperty
   a_ack_slot: assert property (p_ack_slot)
      else $error("data line pulled outside the ack slot");
   property p_ack_rise_low;
      $rose(sda_oe_s) |-> !scl_i;
   endproperty
   a_ack_rise_low: assert property (p_ack_rise_low)
      else $error("ack applied while clock high");
   property p_ack_fall_low;
      $fell(sda_oe_s) |-> !scl_i;
   endproperty
   a_ack_fall_low: assert property (p_ack_fall_low)
      else $error("ack released while clock high");
   property p_ack_stable;
      $rose(scl_i) && sda_oe_s |-> sda_oe_s [*8];
   endproperty
   a_ack_stable: assert property (p_ack_stable)
      else $error("ack dropped in the high phase");
   property p_ack_len;
      $rose(sda_oe_s) |-> ##[1:400] !sda_oe_s;
   endproperty
   a_ack_len: assert property (p_ack_len)
      else $error("ack held too long");
   property p_stretch_low;
      $rose(scl_oe_s) |-> !$past(scl_i);
   endproperty
   a_stretch_low: assert property (p_stretch_low)
      else $error("clock stretch began while clock high");
   property p_stretch_slot;
      $rose(scl_oe_s) |-> bit_cnt == 4'h0;
   endproperty
   a_stretch_slot: assert property (p_stretch_slot)
      else $error("clock stretch outside the byte gap");
   property p_stretch_len;
      $rose(scl_oe_s) |-> ##[1:10] !scl_oe_s;
   endproperty
   a_stretch_len: assert property (p_stretch_len)
      else $error("clock stretch too long");
   c_ack: cover property ($rose(sda_oe_s));
   c_stretch: cover property ($rose(scl_oe_s));
   c_nack: cover property (bit_cnt == 4'h8 && $rose(scl_i) && sda_i);
   c_stop: cover property (scl_i && $rose(sda_i));
endmodule

//--- dv/testbench.sv
// Both link ends joined back to back, checked against a command model.
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic go = 1'b0;
   logic addr_lsb = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic tx_last = 1'b0;
   logic pin = 1'b0;
   logic ps = 1'b0;
   logic [2:0] hw = 3'h0;
   logic tx_take, busy, nack_seen, cmd_valid, ram_we;
   logic [7:0] cmd_byte, ram_data;
   logic [5:0] ram_addr;
   logic [1:0] drive_mode;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] txq[$];
   logic [7:0] got_cmd[$];
   logic [7:0] exp_cmd[$];
   logic [13:0] got_wr[$];
   logic [13:0] exp_wr[$];
   logic [5:0] m_ptr = lsr_pkg::PTR_RESET;
   logic [2:0] m_sub = lsr_pkg::SUB_RESET;
   logic [1:0] m_mode = lsr_pkg::MODE_RESET;
   logic exp_nack;

   always #5 mclk = ~mclk;
   lsr_if bus ();
   lsr_master lsr_master_i (.mclk(mclk), .rstn(rstn), .bus(bus.master), .go(go),
      .addr_lsb(addr_lsb), .tx_byte(tx_byte), .tx_last(tx_last), .tx_take(tx_take),
      .busy(busy), .nack_seen(nack_seen));
   lsr_device lsr_device_i (.mclk(mclk), .rstn(rstn), .bus(bus.device),
      .address_select_pin(pin), .subaddress_in_bit0(hw[0]), .subaddress_in_bit1(hw[1]),
      .subaddress_in_bit2(hw[2]), .power_saving(ps), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .ram_we(ram_we), .ram_addr(ram_addr), .ram_data(ram_data),
      .drive_mode(drive_mode));
   lsr_monitor lsr_monitor_i (.mclk(mclk), .rstn(rstn), .sda_o_s(bus.sda_o_s),
      .sda_oe_s(bus.sda_oe_s), .scl_o_s(bus.scl_o_s), .scl_oe_s(bus.scl_oe_s),
      .sda_i(bus.sda_i), .scl_i(bus.scl_i));

   // Pulses last one cycle, so the falling edge sees each exactly once
   always @(negedge mclk) begin
      if (cmd_valid === 1'b1) got_cmd.push_back(cmd_byte);
      if (ram_we === 1'b1) got_wr.push_back({ram_addr, ram_data});
   end

   task check(input logic [13:0] seen, input logic [13:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Pointer and subaddress state persist across transfers, command phase does not
   task model(input logic lsb);
      logic is_cmd;
      is_cmd = 1'b1;
      exp_nack = (lsb != pin);
      exp_cmd.delete();
      exp_wr.delete();
      if (lsb == pin) foreach (txq[i]) begin
         if (is_cmd) begin
            exp_cmd.push_back(txq[i]);
            if ((txq[i] & lsr_pkg::CMD_LOAD_PTR_MASK) == 8'h00)
               m_ptr = txq[i][5:0];
            else if ((txq[i] & lsr_pkg::CMD_DEV_SEL_MASK) == lsr_pkg::CMD_DEV_SEL)
               m_sub = txq[i][2:0];
            else if ((txq[i] & lsr_pkg::CMD_MODE_MASK) == lsr_pkg::CMD_MODE_SET)
               m_mode = txq[i][1:0];
            is_cmd = txq[i][7];
         end else begin
            if (m_sub == hw) exp_wr.push_back({m_ptr, txq[i]});
            else exp_nack = 1'b1;
            case (m_mode)
               lsr_pkg::MODE_STATIC: m_ptr = m_ptr + lsr_pkg::PTR_STEP_STATIC;
               lsr_pkg::MODE_MUX2: m_ptr = m_ptr + lsr_pkg::PTR_STEP_MUX2;
               lsr_pkg::MODE_MUX3: m_ptr = m_ptr + lsr_pkg::PTR_STEP_MUX3;
               default: m_ptr = m_ptr + lsr_pkg::PTR_STEP_MUX4;
            endcase
            if (m_ptr > lsr_pkg::RAM_LAST) begin
               m_ptr = lsr_pkg::PTR_RESET;
               m_sub = m_sub + 3'h1;
            end
         end
      end
   endtask

   task run(input logic lsb);
      int n;
      int k;
      model(lsb);
      got_cmd.delete();
      got_wr.delete();
      k = 0;
      tx_byte = txq[0];
      tx_last = (txq.size() == 1);
      addr_lsb = lsb;
      go = 1'b1;
      for (n = 0; n < 40000; n++) begin
         @(negedge mclk);
         if (busy === 1'b1) go = 1'b0;
         if (tx_take === 1'b1 && k + 1 < txq.size()) begin
            k++;
            tx_byte = txq[k];
            tx_last = (k + 1 == txq.size());
         end
         if (go === 1'b0 && busy === 1'b0) break;
      end
      if (n == 40000) begin
         fail_count++;
         $display("unexpected at %0t: transfer hung", $time);
         test_done();
      end
      repeat (20) @(negedge mclk);
      check(14'(got_cmd.size()), 14'(exp_cmd.size()));
      foreach (exp_cmd[i]) check(14'(got_cmd[i]), 14'(exp_cmd[i]));
      check(14'(got_wr.size()), 14'(exp_wr.size()));
      foreach (exp_wr[i]) check(got_wr[i], exp_wr[i]);
      check(14'(nack_seen), 14'(exp_nack));
      check(14'(drive_mode), 14'(m_mode));
   endtask

   initial begin
      repeat (10) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      txq = '{8'hC9, 8'hA0, 8'h60, 8'h11, 8'h22};
      run(1'b0);
      ps = 1'b1;
      hw = 3'h5;
      txq = '{8'hC8, 8'hE5, 8'h04, 8'h33, 8'h44, 8'h55};
      run(1'b0);
      pin = 1'b1;
      txq = '{8'hCB, 8'h26, 8'hAA, 8'hBB};
      run(1'b1);
      txq = '{8'hCA, 8'h10, 8'h77};
      run(1'b0);
      txq = '{8'h66};
      run(1'b1);
      hw = 3'h6;
      txq = '{8'h4A, 8'h12, 8'h34};
      run(1'b1);
      test_done();
   end
endmodule
